// file: testbench/pmc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module pmc_cpu_model (
    // Clock, reset and bench commands
    input wire logic clk_sys, rst, irq_req, pin_req,
    // Controller outputs
    input wire logic irq_take, sys_osc_run,
    // Levels towards the controller
    output logic irq_pending, external_clear_pin_n
);
    logic [1:0] osc_cnt;
    // A request stays up until taken, as a real source would
    always_ff @(posedge clk_sys) begin
        if (rst || irq_take) begin
            irq_pending <= 1'h0;
        end else if (irq_req) begin
            irq_pending <= 1'h1;
        end
    end
    // Pin held low until the restarted clock has run a while
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            external_clear_pin_n <= 1'h1;
            osc_cnt <= 2'h0;
        end else if (pin_req) begin
            external_clear_pin_n <= 1'h0;
            osc_cnt <= 2'h0;
        end else if (!external_clear_pin_n && sys_osc_run) begin
            osc_cnt <= osc_cnt + 2'h1;
            if (osc_cnt == 2'h3) external_clear_pin_n <= 1'h1;
        end
    end
endmodule : pmc_cpu_model
`default_nettype wire

// file: testbench/pmc_power_mode_controller_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Port-level checks of the power mode controller
// ----
module pmc_power_mode_controller_properties #(
    parameter int WAIT_UNIT = 4
) (
    // Clock, reset and register port
    input wire logic clk_sys, rst, reg_write, reg_read,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata, reg_rdata,
    // CPU side
    input wire logic irq_pending, irq_enabled, interrupt_mask,
    input wire logic external_clear_pin_n, cpu_halt, cpu_reset,
    input wire logic irq_take, direct_irq_take,
    // Clocks and peripherals
    input wire logic sys_osc_run, sub_osc_run, periph_clk_en,
    input wire logic slow_periph_reset, port_hiz,
    input wire logic second_serial_standby, timer_b_standby,
    input wire logic timer_z_standby, modulator_standby
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Standby is the only mode with ports released and no fast clock
    wire stby = port_hiz && !sys_osc_run;
    wire wake = irq_pending && irq_enabled && !interrupt_mask;
    wire wr_mst = reg_write && reg_addr == pmc_pkg::ADDR_MSTBY_TWO;
    wire rd_mst = reg_read && reg_addr == pmc_pkg::ADDR_MSTBY_TWO;

    mst_upper_a: assert property (wr_mst |=>
        second_serial_standby == $past(reg_wdata[7]) &&
        timer_b_standby == $past(reg_wdata[4]))
        else $error("upper standby bits wrong");
    mst_lower_a: assert property (wr_mst |=>
        timer_z_standby == $past(reg_wdata[1]) &&
        modulator_standby == $past(reg_wdata[0]))
        else $error("lower standby bits wrong");
    rsvd_read_a: assert property (rd_mst |=> reg_rdata ==
        {second_serial_standby, 2'h0, timer_b_standby, 2'h0,
        timer_z_standby, modulator_standby})
        else $error("standby register read wrong");
    rdata_idle_a: assert property (!reg_read |=> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    sub_osc_a: assert property (sub_osc_run)
        else $error("subclock stopped");
    slow_reset_a: assert property (!sys_osc_run |-> slow_periph_reset)
        else $error("slow peripherals not held reset");
    hiz_halt_a: assert property (port_hiz |-> cpu_halt && !periph_clk_en)
        else $error("ports released while running");
    stby_hold_a: assert property (stby && !wake && external_clear_pin_n
        |=> stby) else $error("standby left without cause");
    stby_wake_a: assert property (stby && wake && external_clear_pin_n
        |=> (sys_osc_run && !irq_take) [*3])
        else $error("settling wait skipped");
    pin_reset_a: assert property (cpu_halt && !external_clear_pin_n
        |=> cpu_reset && sys_osc_run) else $error("pin reset ignored");
    take_run_a: assert property (irq_take || direct_irq_take
        |-> !cpu_halt && !cpu_reset) else $error("handler while halted");
    cover property (stby && wake);
    cover property (direct_irq_take);
    cover property (cpu_reset);
endmodule : pmc_power_mode_controller_properties

bind pmc_power_mode_controller pmc_power_mode_controller_properties #(
    .WAIT_UNIT(WAIT_UNIT)) u_props (.*);
`default_nettype wire

// file: testbench/test_pmc_power_mode_controller.sv
`timescale 1ns/1ps
`default_nettype none
module test_pmc_power_mode_controller;
    logic clk_sys = 1'h0, rst = 1'h1, reg_write = 1'h0, reg_read = 1'h0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, s1, s2, d;
    logic sleep_instr = 1'h0, irq_enabled = 1'h1, interrupt_mask = 1'h0;
    logic direct_irq_enabled = 1'h1, irq_req = 1'h0, pin_req = 1'h0;
    logic irq_pending, external_clear_pin_n, cpu_halt, cpu_reset, irq_take;
    logic direct_irq_take, sys_osc_run, sub_osc_run, periph_clk_en;
    logic slow_periph_reset, second_serial_standby, timer_b_standby;
    logic timer_z_standby, modulator_standby, retain_keep_domain, port_hiz;
    logic [2:0] m;
    logic [3:0] b;
    int miscompares = 0, total_checks = 0, cycles = 0, n;

    pmc_power_mode_controller #(.WAIT_UNIT(4)) DUT (.*);
    pmc_cpu_model u_cpu (.*);

    initial forever #2 clk_sys = ~clk_sys;
    // Hang guard, far above the few thousand cycles needed
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            end_sim();
        end
    end
    // ----
    // Bus, compare and expectation helpers
    // ----
    task chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'h1;
        @(posedge clk_sys);
        reg_write <= 1'h0;
    endtask : wr
    task rchk(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'h1;
        @(posedge clk_sys);
        reg_read <= 1'h0;
        #1 chk(reg_rdata, e);
    endtask : rchk
    task pulse_irq();
        @(posedge clk_sys);
        irq_req <= 1'h1;
        @(posedge clk_sys);
        irq_req <= 1'h0;
    endtask : pulse_irq
    // Bounded wait for the accepted interrupt pulse
    task wait_take(output int k);
        for (k = 0; k < 200; k++) begin
            @(posedge clk_sys);
            #1 if (irq_take === 1'h1) break;
        end
        chk(irq_take, 8'h01);
    endtask : wait_take
    function logic [2:0] sleep_mode(input logic [7:0] a, input logic [7:0] c);
        if (c[5] && direct_irq_enabled)
            return c[6] ? pmc_pkg::PMC_SUBACTIVE : pmc_pkg::PMC_ACTIVE;
        if (a[7] && !c[5]) return pmc_pkg::PMC_STANDBY;
        return c[7] ? pmc_pkg::PMC_SUBSLEEP : pmc_pkg::PMC_SLEEP;
    endfunction : sleep_mode
    // Level outputs per mode: halt, ports released, fast osc, kept, slow rst
    function logic [7:0] mode_outs(input logic [2:0] md);
        return {3'h0, md == 3'h2 || md == 3'h3 || md == 3'h4, md == 3'h4,
            md == 3'h0 || md == 3'h2, md == 3'h1 || md == 3'h3 || md == 3'h4,
            md == 3'h1 || md == 3'h3 || md == 3'h4};
    endfunction : mode_outs
    function logic [2:0] wake_mode(input logic [2:0] md, input logic ls);
        if (md == pmc_pkg::PMC_STANDBY || !ls) return pmc_pkg::PMC_ACTIVE;
        return pmc_pkg::PMC_SUBACTIVE;
    endfunction : wake_mode

    initial begin
        void'($urandom(89));
        repeat (4) @(posedge clk_sys);
        rst <= 1'h0;
        for (int a = 0; a < 4; a++) rchk(a[3:0], 8'h00);
        wr(4'hF, 8'hFF);
        rchk(4'hF, 8'h00);
        // Standby bits: all ones first, then random
        for (int i = 0; i < 6; i++) begin
            d = (i == 0) ? 8'hFF : 8'($urandom);
            wr(pmc_pkg::ADDR_MSTBY_TWO, d);
            rchk(pmc_pkg::ADDR_MSTBY_TWO, d & 8'h93);
            chk({second_serial_standby, timer_b_standby, timer_z_standby,
                modulator_standby}, {d[7], d[4], d[1], d[0]});
        end
        // All sixteen control combinations, then random ones
        for (int i = 0; i < 24; i++) begin
            b = (i < 16) ? i[3:0] : 4'($urandom);
            s1 = {b[3], 3'($urandom), 4'h0};
            s2 = {b[2], b[1], b[0], 1'h1, 2'($urandom), 2'h0};
            direct_irq_enabled <= 1'($urandom);
            wr(pmc_pkg::ADDR_SYS_ONE, s1);
            wr(pmc_pkg::ADDR_SYS_TWO, s2);
            @(posedge clk_sys);
            sleep_instr <= 1'h1;
            @(posedge clk_sys);
            sleep_instr <= 1'h0;
            m = sleep_mode(s1, s2);
            #1 chk(direct_irq_take, 8'(s2[5] && direct_irq_enabled));
            rchk(pmc_pkg::ADDR_STATUS, {2'h0, s2[4:2], m});
            chk({cpu_halt, port_hiz, sys_osc_run, retain_keep_domain,
                slow_periph_reset}, mode_outs(m));
            // Divided enable: period of 8 << low code bits, 128 cycles
            if (m == pmc_pkg::PMC_ACTIVE || m == pmc_pkg::PMC_SLEEP) begin
                n = 0;
                repeat (128) begin
                    @(posedge clk_sys);
                    #1 n += periph_clk_en;
                end
                chk(8'(n), 8'(16 >> s2[3:2]));
            end
            if (!m[0] && m != pmc_pkg::PMC_ACTIVE || m == 3'h3) begin
                interrupt_mask <= (i % 4 == 0);
                pulse_irq();
                if (i % 4 == 0) begin
                    repeat (6) @(posedge clk_sys);
                    rchk(pmc_pkg::ADDR_STATUS, {2'h0, s2[4:2], m});
                    interrupt_mask <= 1'h0;
                end
                wait_take(n);
                if (m == pmc_pkg::PMC_STANDBY)
                    chk(8'(n >= 4 * (s1[6:4] + 1)), 8'h01);
                rchk(pmc_pkg::ADDR_STATUS,
                    {2'h0, s2[4:2], wake_mode(m, s2[6])});
                chk({cpu_halt, port_hiz, sys_osc_run, retain_keep_domain,
                    slow_periph_reset},
                    mode_outs(wake_mode(m, s2[6])));
            end
        end
        // Pin reset out of subsleep clears everything
        wr(pmc_pkg::ADDR_SYS_ONE, 8'h00);
        wr(pmc_pkg::ADDR_SYS_TWO, 8'h80);
        @(posedge clk_sys);
        sleep_instr <= 1'h1;
        @(posedge clk_sys);
        sleep_instr <= 1'h0;
        pin_req <= 1'h1;
        @(posedge clk_sys);
        pin_req <= 1'h0;
        repeat (20) @(posedge clk_sys);
        rchk(pmc_pkg::ADDR_SYS_TWO, 8'h00);
        rchk(pmc_pkg::ADDR_STATUS, 8'h00);
        rchk(pmc_pkg::ADDR_MSTBY_TWO, 8'h00);
        chk(8'(cpu_reset), 8'h00);
        end_sim();
    end

    task end_sim();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim
endmodule : test_pmc_power_mode_controller
`default_nettype wire

// file: verilog/pmc_pkg.sv
package pmc_pkg;

    // ------------------------------------------------------------------
    // Register map (word index = byte offset / 4 not used: plain port)
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_SYS_ONE = 4'h0; // system_control_one
    localparam logic [3:0] ADDR_SYS_TWO = 4'h1; // system_control_two
    localparam logic [3:0] ADDR_MSTBY_TWO = 4'h2; // module_standby_control_two
    localparam logic [3:0] ADDR_STATUS = 4'h3; // mode and clock status

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    // system_control_one
    localparam int SYS1_STANDBY_SELECT_BIT = 7;
    localparam int SYS1_WAIT_LSB = 4;
    // system_control_two
    localparam int SYS2_SUBSLEEP_SELECT_BIT = 7;
    localparam int SYS2_LOW_SPEED_ON_BIT = 6;
    localparam int SYS2_DIRECT_TRANSITION_ON_BIT = 5;
    localparam int SYS2_DIV_LSB = 2;
    // module_standby_control_two
    localparam int MST_SER2_BIT = 7;
    localparam int MST_TMB_BIT = 4;
    localparam int MST_TMZ_BIT = 1;
    localparam int MST_PWM_BIT = 0;
    localparam logic [7:0] MST_WRITE_MASK = 8'h93;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] SYS1_RESET = 8'h00;
    localparam logic [7:0] SYS2_RESET = 8'h00;
    localparam logic [7:0] MST_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Timing: settling wait per wakeup_wait_select code, in cycles
    // ------------------------------------------------------------------
    localparam int WAIT_BASE_CYCLES = 8192;

    // ------------------------------------------------------------------
    // Operating modes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PMC_ACTIVE = 3'b000,
        PMC_SUBACTIVE = 3'b001,
        PMC_SLEEP = 3'b010,
        PMC_SUBSLEEP = 3'b011,
        PMC_STANDBY = 3'b100,
        PMC_SETTLE = 3'b101,
        PMC_RESET = 3'b110
    } pmc_mode_t;

endpackage : pmc_pkg

// file: verilog/pmc_power_mode_controller.sv
`timescale 1ns/1ps
`default_nettype none

module pmc_power_mode_controller #(
    parameter int WAIT_UNIT = pmc_pkg::WAIT_BASE_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // CPU side
    input wire logic sleep_instr,
    input wire logic irq_pending,
    input wire logic irq_enabled,
    input wire logic interrupt_mask,
    input wire logic direct_irq_enabled,
    input wire logic external_clear_pin_n,
    output logic cpu_halt,
    output logic cpu_reset,
    output logic irq_take,
    output logic direct_irq_take,
    // Clocks and peripherals
    output logic sys_osc_run,
    output logic sub_osc_run,
    output logic periph_clk_en,
    output logic slow_periph_reset,
    output logic second_serial_standby,
    output logic timer_b_standby,
    output logic timer_z_standby,
    output logic modulator_standby,
    output logic retain_keep_domain,
    output logic port_hiz
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        pmc_pkg::pmc_mode_t mode;
        logic [7:0] sys_one;
        logic [7:0] sys_two;
        logic [7:0] mstby;
        logic [2:0] div_live;
        logic [5:0] div_cnt;
        logic [18:0] wait_cnt;
        logic wait_reset;
        logic [7:0] rdata;
        logic irq_take;
        logic direct_take;
        logic periph_rst;
    } pmc_state_t;

    pmc_state_t st;
    pmc_state_t next_st;

    logic [5:0] div_limit;
    logic [18:0] wait_len;
    logic wake_req;

    // Divider terminal count from the applied code
    always_comb begin
        unique case (st.div_live)
            3'b100: div_limit = 6'h07;
            3'b101: div_limit = 6'h0F;
            3'b110: div_limit = 6'h1F;
            3'b111: div_limit = 6'h3F;
            default: div_limit = 6'h00;
        endcase
    end

    // Settling length grows with the select code; never below one unit
    assign wait_len = 19'(WAIT_UNIT) * 19'(
        {16'h0000, st.sys_one[pmc_pkg::SYS1_WAIT_LSB +: 3]} + 19'h1);

    // A wake needs an enabled request and a clear mask bit
    assign wake_req = irq_pending && irq_enabled && !interrupt_mask;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.irq_take = 1'b0;
        next_st.direct_take = 1'b0;
        next_st.periph_rst = 1'b0;

        // Register writes; reserved bits masked off
        if (reg_write) begin
            unique case (reg_addr)
                pmc_pkg::ADDR_SYS_ONE: next_st.sys_one = reg_wdata & 8'hF0;
                pmc_pkg::ADDR_SYS_TWO: next_st.sys_two = reg_wdata & 8'hFC;
                pmc_pkg::ADDR_MSTBY_TWO:
                    next_st.mstby = reg_wdata & pmc_pkg::MST_WRITE_MASK;
                default: ;
            endcase
        end

        // Read data stands one cycle after the strobe
        next_st.rdata = 8'h00;
        if (reg_read) begin
            unique case (reg_addr)
                pmc_pkg::ADDR_SYS_ONE: next_st.rdata = st.sys_one;
                pmc_pkg::ADDR_SYS_TWO: next_st.rdata = st.sys_two;
                pmc_pkg::ADDR_MSTBY_TWO: next_st.rdata = st.mstby;
                pmc_pkg::ADDR_STATUS:
                    next_st.rdata = {2'b00, st.div_live, st.mode};
                default: next_st.rdata = 8'h00;
            endcase
        end

        // Divided peripheral clock enable
        if (st.div_cnt >= div_limit) begin
            next_st.div_cnt = 6'h00;
        end else begin
            next_st.div_cnt = st.div_cnt + 6'h01;
        end

        unique case (st.mode)
            pmc_pkg::PMC_ACTIVE, pmc_pkg::PMC_SUBACTIVE: begin
                if (sleep_instr) begin
                    // New divider code only takes hold at a sleep instruction
                    next_st.div_live = st.sys_two[pmc_pkg::SYS2_DIV_LSB +: 3];
                    next_st.div_cnt = 6'h00;
                    if (st.sys_two[pmc_pkg::SYS2_SUBSLEEP_SELECT_BIT]) begin
                        next_st.periph_rst = 1'b1;
                    end
                    if (st.sys_two[pmc_pkg::SYS2_DIRECT_TRANSITION_ON_BIT] &&
                        direct_irq_enabled && !interrupt_mask) begin
                        // Program keeps running across the switch
                        next_st.direct_take = 1'b1;
                        next_st.mode = st.sys_two[pmc_pkg::SYS2_LOW_SPEED_ON_BIT] ?
                            pmc_pkg::PMC_SUBACTIVE : pmc_pkg::PMC_ACTIVE;
                    end else if (!st.sys_two[pmc_pkg::SYS2_DIRECT_TRANSITION_ON_BIT] &&
                                 st.sys_one[pmc_pkg::SYS1_STANDBY_SELECT_BIT]) begin
                        next_st.mode = pmc_pkg::PMC_STANDBY;
                    end else if (st.sys_two[pmc_pkg::SYS2_SUBSLEEP_SELECT_BIT]) begin
                        next_st.mode = pmc_pkg::PMC_SUBSLEEP;
                    end else begin
                        next_st.mode = pmc_pkg::PMC_SLEEP;
                    end
                end
            end
            pmc_pkg::PMC_SLEEP, pmc_pkg::PMC_SUBSLEEP: begin
                if (!external_clear_pin_n) begin
                    next_st.mode = pmc_pkg::PMC_RESET;
                end else if (wake_req) begin
                    next_st.irq_take = 1'b1;
                    if (st.sys_two[pmc_pkg::SYS2_SUBSLEEP_SELECT_BIT]) begin
                        next_st.periph_rst = 1'b1;
                    end
                    next_st.mode = st.sys_two[pmc_pkg::SYS2_LOW_SPEED_ON_BIT] ?
                        pmc_pkg::PMC_SUBACTIVE : pmc_pkg::PMC_ACTIVE;
                end
            end
            pmc_pkg::PMC_STANDBY: begin
                if (!external_clear_pin_n) begin
                    next_st.mode = pmc_pkg::PMC_RESET;
                end else if (wake_req) begin
                    // Restart the oscillator and let it settle first
                    next_st.mode = pmc_pkg::PMC_SETTLE;
                    next_st.wait_cnt = 19'h00001;
                end
            end
            pmc_pkg::PMC_SETTLE: begin
                if (!external_clear_pin_n) begin
                    next_st.mode = pmc_pkg::PMC_RESET;
                end else if (st.wait_cnt >= wait_len) begin
                    next_st.irq_take = 1'b1;
                    if (st.sys_two[pmc_pkg::SYS2_SUBSLEEP_SELECT_BIT]) begin
                        next_st.periph_rst = 1'b1;
                    end
                    next_st.mode = pmc_pkg::PMC_ACTIVE;
                end else begin
                    next_st.wait_cnt = st.wait_cnt + 19'h00001;
                end
            end
            pmc_pkg::PMC_RESET: begin
                // Leave only when the pin is released high
                if (external_clear_pin_n) begin
                    next_st = '0;
                    next_st.mode = pmc_pkg::PMC_ACTIVE;
                end
            end
            default: next_st.mode = pmc_pkg::PMC_ACTIVE;
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st <= '0;
            st.sys_one <= pmc_pkg::SYS1_RESET;
            st.sys_two <= pmc_pkg::SYS2_RESET;
            st.mstby <= pmc_pkg::MST_RESET;
            st.mode <= pmc_pkg::PMC_ACTIVE;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata = st.rdata;
    assign irq_take = st.irq_take;
    assign direct_irq_take = st.direct_take;
    // CPU stops in every halt mode and during the settling wait
    assign cpu_halt = (st.mode == pmc_pkg::PMC_SLEEP) ||
        (st.mode == pmc_pkg::PMC_SUBSLEEP) ||
        (st.mode == pmc_pkg::PMC_STANDBY) ||
        (st.mode == pmc_pkg::PMC_SETTLE);
    assign cpu_reset = (st.mode == pmc_pkg::PMC_RESET);
    // Main oscillator also runs during settle and reset hold
    assign sys_osc_run = (st.mode == pmc_pkg::PMC_ACTIVE) ||
        (st.mode == pmc_pkg::PMC_SLEEP) ||
        (st.mode == pmc_pkg::PMC_SETTLE) ||
        (st.mode == pmc_pkg::PMC_RESET);
    assign sub_osc_run = 1'b1;
    assign periph_clk_en = (st.mode == pmc_pkg::PMC_ACTIVE ||
        st.mode == pmc_pkg::PMC_SLEEP) && (st.div_cnt == 6'h00);
    assign slow_periph_reset = st.periph_rst ||
        (st.mode == pmc_pkg::PMC_SUBACTIVE) ||
        (st.mode == pmc_pkg::PMC_SUBSLEEP) ||
        (st.mode == pmc_pkg::PMC_STANDBY);
    // Retained units keep state; software access not gated here
    assign retain_keep_domain = (st.mode != pmc_pkg::PMC_ACTIVE) &&
        (st.mode != pmc_pkg::PMC_SLEEP);
    assign second_serial_standby = st.mstby[pmc_pkg::MST_SER2_BIT];
    assign timer_b_standby = st.mstby[pmc_pkg::MST_TMB_BIT];
    assign timer_z_standby = st.mstby[pmc_pkg::MST_TMZ_BIT];
    assign modulator_standby = st.mstby[pmc_pkg::MST_PWM_BIT];
    assign port_hiz = (st.mode == pmc_pkg::PMC_STANDBY) ||
        (st.mode == pmc_pkg::PMC_SETTLE);

endmodule : pmc_power_mode_controller
`default_nettype wire
